// ==== src/nvmpc_params.svh ====
// Constants for the non-volatile memory protection controller.
`ifndef NVMPC_PARAMS_SVH
`define NVMPC_PARAMS_SVH
`define NVMPC_OFS_UNLOCK     12'h000
`define NVMPC_OFS_STATUS     12'h004
`define NVMPC_OFS_BOOT_CFG   12'h008
`define NVMPC_KEY1           8'h56
`define NVMPC_KEY2           8'hae
`define NVMPC_ST_UNLOCKED    0
`define NVMPC_ST_READOUT     1
`define NVMPC_ST_ERASE       2
`define NVMPC_ST_BOOT_VALID  3
`define NVMPC_ST_LOADED      4
`define NVMPC_ST_STEPS_LSB   8
`define NVMPC_BOOT_STEP_SH   9
`define NVMPC_VECTOR_END     17'h00080
`define NVMPC_RO_ACTIVE      8'haa
`define NVMPC_RO_CLEARED     8'h00
`define NVMPC_OPT_BOOT       2'h0
`define NVMPC_OPT_BOOT_N     2'h1
`define NVMPC_OPT_READOUT    2'h2
`define NVMPC_ERASE_CYCLES   16
`endif

// ==== src/nvmpc_pkg.sv ====
// Types shared by the protection controller modules.
package nvmpc_pkg;
	typedef enum logic [1:0] {
		NVMPC_ER_IDLE = 2'b00,
		NVMPC_ER_PROG = 2'b01,
		NVMPC_ER_DATA = 2'b10,
		NVMPC_ER_DONE = 2'b11
	} nvmpc_erase_st_t;
	typedef enum logic [1:0] {
		NVMPC_SP_PROG = 2'b00,
		NVMPC_SP_DATA = 2'b01,
		NVMPC_SP_OPT  = 2'b10,
		NVMPC_SP_NONE = 2'b11
	} nvmpc_space_t;
endpackage

// ==== src/nvmpc_erase.sv ====
// Global erase sequencer: wipes program memory, then data memory.
`include "nvmpc_params.svh"
module nvmpc_erase #(
	parameter int ERASE_CYCLES = `NVMPC_ERASE_CYCLES
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	// Control
	input  wire logic start,
	output logic      busy,
	output logic      done,
	// Erase strobes to the memory arrays
	output logic      erase_prog,
	output logic      erase_data
);
	localparam int CW = $clog2(ERASE_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(ERASE_CYCLES - 1);

	nvmpc_pkg::nvmpc_erase_st_t st_ff;
	nvmpc_pkg::nvmpc_erase_st_t nxt_st;
	logic [CW-1:0]              cnt_ff;

	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			nvmpc_pkg::NVMPC_ER_IDLE: if (start) nxt_st = nvmpc_pkg::NVMPC_ER_PROG;
			nvmpc_pkg::NVMPC_ER_PROG: if (cnt_ff == LAST) nxt_st = nvmpc_pkg::NVMPC_ER_DATA;
			nvmpc_pkg::NVMPC_ER_DATA: if (cnt_ff == LAST) nxt_st = nvmpc_pkg::NVMPC_ER_DONE;
			nvmpc_pkg::NVMPC_ER_DONE: nxt_st = nvmpc_pkg::NVMPC_ER_IDLE;
			default: nxt_st = nvmpc_pkg::NVMPC_ER_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st_ff <= nvmpc_pkg::NVMPC_ER_IDLE;
		else if (ce)
			st_ff <= nxt_st;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_ff <= '0;
		else if (ce) begin
			if (nxt_st != st_ff)
				cnt_ff <= '0;
			else if (st_ff == nvmpc_pkg::NVMPC_ER_PROG || st_ff == nvmpc_pkg::NVMPC_ER_DATA)
				cnt_ff <= cnt_ff + 1'b1;
		end
	end

	assign busy       = (st_ff != nvmpc_pkg::NVMPC_ER_IDLE);
	assign done       = (st_ff == nvmpc_pkg::NVMPC_ER_DONE);
	assign erase_prog = (st_ff == nvmpc_pkg::NVMPC_ER_PROG);
	assign erase_data = (st_ff == nvmpc_pkg::NVMPC_ER_DATA);
endmodule

// ==== src/nvmpc_top.sv ====
// Protection controller for program memory, data memory and option bytes.
`include "nvmpc_params.svh"
module nvmpc_top #(
	parameter int ERASE_CYCLES = `NVMPC_ERASE_CYCLES
) (
	// Clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Option byte values held in the array, sampled after reset
	input  wire logic [7:0]  opt_boot_in,
	input  wire logic [7:0]  opt_boot_n_in,
	input  wire logic [7:0]  opt_readout_in,
	// Application write check
	input  wire logic        cpu_wr_req,
	input  wire logic [1:0]  cpu_wr_space,
	input  wire logic [16:0] cpu_wr_addr,
	output logic             cpu_wr_allow,
	// Debug module access from the single wire debug port
	input  wire logic        dbg_req,
	input  wire logic        dbg_write,
	input  wire logic [1:0]  dbg_space,
	input  wire logic [16:0] dbg_addr,
	input  wire logic [7:0]  dbg_wdata,
	output logic             dbg_grant,
	output logic             dbg_deny,
	// Protection state and erase strobes
	output logic [7:0]       boot_area_lock,
	output logic [7:0]       boot_area_lock_complement,
	output logic             readout_lock,
	output logic             in_app_programming,
	output logic             erase_prog,
	output logic             erase_data
);
	logic        unlocked_ff;
	logic        key_stage_ff;
	logic        loaded_ff;
	logic [7:0]  boot_ff;
	logic [7:0]  boot_n_ff;
	logic [7:0]  readout_ff;
	logic [31:0] prdata_ff;
	logic        slverr_ff;
	logic        erase_busy;
	logic        erase_done;
	logic        erase_start;
	logic        apb_setup;
	logic        apb_wr;
	logic        readout_on;
	logic        boot_valid;
	logic [16:0] boot_bytes;
	logic        dbg_opt_wr;
	logic        dbg_ro_clear;
	logic        mapped;
	logic [31:0] nxt_prdata;

	assign apb_setup  = psel && !penable;
	assign apb_wr     = psel && penable && pwrite;
	assign mapped     = (paddr == `NVMPC_OFS_UNLOCK) || (paddr == `NVMPC_OFS_STATUS) ||
	                    (paddr == `NVMPC_OFS_BOOT_CFG);
	assign readout_on = (readout_ff == `NVMPC_RO_ACTIVE);
	assign boot_valid = (boot_n_ff == ~boot_ff);
	assign boot_bytes = boot_valid ? {boot_ff, 9'h000} : 17'h00000;

	// Option bytes are captured one edge after reset release; a strap is never
	// loaded by the asynchronous reset itself.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			loaded_ff <= 1'b0;
		else if (ce)
			loaded_ff <= 1'b1;
	end

	// Debug accesses are decided in one cycle; the readout byte clear is the
	// only request let through a set lock, and only to start the erase.
	assign dbg_ro_clear = dbg_req && dbg_write && loaded_ff && !erase_busy &&
	                      dbg_space == nvmpc_pkg::NVMPC_SP_OPT &&
	                      dbg_addr[1:0] == `NVMPC_OPT_READOUT &&
	                      dbg_wdata != `NVMPC_RO_ACTIVE && readout_on;
	assign dbg_grant    = dbg_req && loaded_ff && !erase_busy && !readout_on;
	assign dbg_deny     = dbg_req && !dbg_grant;
	assign dbg_opt_wr   = dbg_grant && dbg_write && dbg_space == nvmpc_pkg::NVMPC_SP_OPT;
	assign erase_start  = dbg_ro_clear;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_ff   <= 8'h00;
			boot_n_ff <= 8'h00;
		end else if (ce) begin
			if (!loaded_ff) begin
				boot_ff   <= opt_boot_in;
				boot_n_ff <= opt_boot_n_in;
			end else if (dbg_opt_wr && dbg_addr[1:0] == `NVMPC_OPT_BOOT)
				boot_ff   <= dbg_wdata;
			else if (dbg_opt_wr && dbg_addr[1:0] == `NVMPC_OPT_BOOT_N)
				boot_n_ff <= dbg_wdata;
		end
	end

	// Reset value keeps the lock on until the real byte is known.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			readout_ff <= `NVMPC_RO_ACTIVE;
		else if (ce) begin
			if (!loaded_ff)
				readout_ff <= opt_readout_in;
			else if (erase_done)
				readout_ff <= `NVMPC_RO_CLEARED;
			else if (dbg_opt_wr && dbg_addr[1:0] == `NVMPC_OPT_READOUT)
				readout_ff <= dbg_wdata;
		end
	end

	nvmpc_erase #(
		.ERASE_CYCLES(ERASE_CYCLES)
	) u_erase (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.start     (erase_start),
		.busy      (erase_busy),
		.done      (erase_done),
		.erase_prog(erase_prog),
		.erase_data(erase_data)
	);

	// Unlock needs KEY1 then KEY2 as consecutive writes to the unlock register; any other write to it, a lone KEY1 included, relocks.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_stage_ff <= 1'b0;
			unlocked_ff  <= 1'b0;
		end else if (ce && apb_wr && paddr == `NVMPC_OFS_UNLOCK) begin
			key_stage_ff <= (pwdata[7:0] == `NVMPC_KEY1) && !key_stage_ff;
			unlocked_ff  <= key_stage_ff && pwdata[7:0] == `NVMPC_KEY2;
		end
	end

	// Writes to the boot configuration word are accepted but change nothing.
	always_comb begin
		nxt_prdata = 32'h00000000;
		case (paddr)
			`NVMPC_OFS_STATUS: begin
				nxt_prdata[`NVMPC_ST_UNLOCKED]   = unlocked_ff;
				nxt_prdata[`NVMPC_ST_READOUT]    = readout_on;
				nxt_prdata[`NVMPC_ST_ERASE]      = erase_busy;
				nxt_prdata[`NVMPC_ST_BOOT_VALID] = boot_valid;
				nxt_prdata[`NVMPC_ST_LOADED]     = loaded_ff;
				nxt_prdata[`NVMPC_ST_STEPS_LSB +: 8] = boot_valid ? boot_ff : 8'h00;
			end
			`NVMPC_OFS_BOOT_CFG: nxt_prdata = {16'h0000, boot_n_ff, boot_ff};
			default: nxt_prdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h00000000;
			slverr_ff <= 1'b0;
		end else if (ce && apb_setup) begin
			prdata_ff <= pwrite ? 32'h00000000 : nxt_prdata;
			slverr_ff <= !mapped;
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && slverr_ff;

	// Boot area starts at address zero, so the vector table is inside it whenever a valid pair gives a nonzero size.
	assign cpu_wr_allow = cpu_wr_req && unlocked_ff && !erase_busy && loaded_ff &&
	                      (cpu_wr_space == nvmpc_pkg::NVMPC_SP_DATA ||
	                       (cpu_wr_space == nvmpc_pkg::NVMPC_SP_PROG &&
	                        cpu_wr_addr >= boot_bytes));

	assign boot_area_lock            = boot_ff;
	assign boot_area_lock_complement = boot_n_ff;
	assign readout_lock              = readout_on;
	assign in_app_programming        = unlocked_ff;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	wr_lock_hold_a: assert property (cpu_wr_allow |-> unlocked_ff &&
		(cpu_wr_space == nvmpc_pkg::NVMPC_SP_DATA ||
		 cpu_wr_space == nvmpc_pkg::NVMPC_SP_PROG))
		else $error("write allowed while locked");
	unlock_keys_a: assert property ($rose(unlocked_ff) |->
		$past(apb_wr && paddr == `NVMPC_OFS_UNLOCK && pwdata[7:0] == `NVMPC_KEY2 &&
		key_stage_ff))
		else $error("unlock without key sequence");
	boot_size_a: assert property (cpu_wr_allow && boot_valid &&
		cpu_wr_space == nvmpc_pkg::NVMPC_SP_PROG |-> cpu_wr_addr >= {boot_ff, 9'h000})
		else $error("write inside boot area");
	sw_boot_ignored_a: assert property (ce && apb_wr && loaded_ff && !dbg_opt_wr |=>
		$stable(boot_ff) && $stable(boot_n_ff))
		else $error("software changed boot lock");
	vector_cover_a: assert property (cpu_wr_allow && boot_valid && boot_ff != 8'h00 &&
		cpu_wr_space == nvmpc_pkg::NVMPC_SP_PROG |-> cpu_wr_addr >= `NVMPC_VECTOR_END)
		else $error("vector area written");
	readout_load_a: assert property ($rose(loaded_ff) |->
		readout_on == ($past(opt_readout_in) == `NVMPC_RO_ACTIVE))
		else $error("readout lock not taken from option");
	dbg_blocked_a: assert property (readout_on && dbg_req |-> dbg_deny && !dbg_grant)
		else $error("debug access under readout lock");
	dbg_no_write_a: assert property (ce && loaded_ff && readout_on && dbg_req |=>
		$stable(boot_ff) && $stable(boot_n_ff))
		else $error("debug write landed under readout lock");
	erase_first_a: assert property (ce && loaded_ff && $past(loaded_ff) &&
		$fell(readout_on) |-> $past(erase_done))
		else $error("readout lock cleared without erase");
	erase_order_a: assert property (ce && erase_start |=> erase_prog [*2])
		else $error("erase did not start");
	pair_check_a: assert property (!boot_valid && cpu_wr_req && unlocked_ff && loaded_ff &&
		!erase_busy && cpu_wr_space == nvmpc_pkg::NVMPC_SP_PROG |-> cpu_wr_allow)
		else $error("invalid pair still applied");
	// A low enable must hold every piece of protection state, or a stalled
	// clock domain could slip a key or a lock change through.
	ce_freeze_a: assert property (!ce |=> $stable(unlocked_ff) && $stable(key_stage_ff) &&
		$stable(readout_ff) && $stable(boot_ff) && $stable(prdata_ff) && $stable(erase_busy))
		else $error("state moved while clock enable low");

	unlock_seen_c: cover property ($rose(unlocked_ff));
	erase_seen_c: cover property (erase_start ##[1:100] erase_done);
	dbg_grant_c: cover property (dbg_grant && dbg_opt_wr);
	open_pair_c: cover property (!boot_valid && cpu_wr_allow &&
		cpu_wr_space == nvmpc_pkg::NVMPC_SP_PROG);
endmodule

// ==== sim/nvmpc_dbg_host.sv ====
// Debug host model that drives the debug access port of the controller.
module nvmpc_dbg_host (
	// Clock
	input  wire logic        pclk,
	// Debug access
	output logic             dbg_req,
	output logic             dbg_write,
	output logic [1:0]       dbg_space,
	output logic [16:0]      dbg_addr,
	output logic [7:0]       dbg_wdata,
	input  wire logic        dbg_grant,
	input  wire logic        dbg_deny
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		dbg_req = 1'b0;
		dbg_write = 1'b0;
		dbg_space = 2'h3;
		dbg_addr = 17'h0;
		dbg_wdata = 8'h0;
	end
	task automatic access(input logic w, input logic [1:0] sp, input logic [16:0] a,
		input logic [7:0] d, output logic g, output logic dn);
		@(posedge pclk);
		dbg_req <= 1'b1;
		dbg_write <= w;
		dbg_space <= sp;
		dbg_addr <= a;
		dbg_wdata <= d;
		#1 g = dbg_grant;
		dn = dbg_deny;
		@(posedge pclk);
		dbg_req <= 1'b0;
		// Released address and data lines show the inverse so a stale value cannot pass for a live one.
		dbg_addr <= ~a;
		dbg_wdata <= ~d;
		#1;
	endtask
endmodule

// ==== sim/nvm_protection_control_test.sv ====
// Self-checking bench for the memory protection controller.
`include "nvmpc_params.svh"
module nvm_protection_control_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int EC = 4;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [7:0]  opt_boot_in = 8'h0;
	logic [7:0]  opt_boot_n_in = 8'h0;
	logic [7:0]  opt_readout_in = 8'h0;
	logic        cpu_wr_req = 1'b0;
	logic [1:0]  cpu_wr_space = 2'h3;
	logic [16:0] cpu_wr_addr = 17'h0;
	logic [31:0] prdata, r;
	logic        pready, pslverr, cpu_wr_allow, e;
	logic        dbg_req, dbg_write, dbg_grant, dbg_deny;
	logic [1:0]  dbg_space;
	logic [16:0] dbg_addr;
	logic [7:0]  dbg_wdata, boot_area_lock, boot_area_lock_complement;
	logic        readout_lock, in_app_programming, erase_prog, erase_data;
	int          fails = 0;
	int          check_count = 0;

	always #12.5 pclk = ~pclk;

	nvmpc_top #(.ERASE_CYCLES(EC)) dut_u (.pclk, .presetn, .ce, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .opt_boot_in,
		.opt_boot_n_in, .opt_readout_in, .cpu_wr_req, .cpu_wr_space, .cpu_wr_addr,
		.cpu_wr_allow, .dbg_req, .dbg_write, .dbg_space, .dbg_addr, .dbg_wdata,
		.dbg_grant, .dbg_deny, .boot_area_lock, .boot_area_lock_complement,
		.readout_lock, .in_app_programming, .erase_prog, .erase_data);
	nvmpc_dbg_host dbg_u (.pclk, .dbg_req, .dbg_write, .dbg_space, .dbg_addr,
		.dbg_wdata, .dbg_grant, .dbg_deny);

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check_word(input string n, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x) begin
			$display("ERROR %s expected %h seen %h", n, x, g);
			fails++;
		end
	endtask
	task automatic check_bit(input string n, input logic x, input logic g);
		check_count++;
		if (g !== x) begin
			$display("ERROR %s expected %b seen %b", n, x, g);
			fails++;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
	endtask
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] x);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0, rd, err);
		check_word(n, x, rd);
	endtask
	task automatic cpu(input logic [1:0] sp, input logic [16:0] a, input logic x);
		@(posedge pclk);
		cpu_wr_req <= 1'b1;
		cpu_wr_space <= sp;
		cpu_wr_addr <= a;
		#1 check_bit("cpu_wr_allow", x, cpu_wr_allow);
	endtask
	task automatic dbg(input logic w, input logic [1:0] sp, input logic [16:0] a,
		input logic [7:0] d, input logic x);
		logic g;
		logic dn;
		dbg_u.access(w, sp, a, d, g, dn);
		check_bit("dbg_grant", x, g);
		check_bit("dbg_deny", !x, dn);
	endtask
	task automatic rst(input logic [7:0] b, input logic [7:0] bn, input logic [7:0] ro);
		presetn <= 1'b0;
		opt_boot_in <= b;
		opt_boot_n_in <= bn;
		opt_readout_in <= ro;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask

	// The run needs under a hundred cycles, so this span only trips on a hang.
	initial begin
		#100000;
		fails++;
		tally_and_finish;
	end
	initial begin
		rst(8'h04, 8'hfb, 8'h00);
		rdc("status", `NVMPC_OFS_STATUS, 32'h0000_0418);
		rdc("boot_cfg", `NVMPC_OFS_BOOT_CFG, 32'h0000_fb04);
		cpu(2'h1, 17'h00100, 1'b0);
		wr(`NVMPC_OFS_UNLOCK, 32'h56);
		wr(`NVMPC_OFS_UNLOCK, 32'hae);
		check_bit("in_app", 1'b1, in_app_programming);
		cpu(2'h0, 17'h00000, 1'b0);
		cpu(2'h0, 17'h007ff, 1'b0);
		cpu(2'h0, 17'h00800, 1'b1);
		cpu(2'h1, 17'h00010, 1'b1);
		cpu(2'h2, 17'h00000, 1'b0);
		wr(`NVMPC_OFS_BOOT_CFG, 32'h0000_00ff);
		rdc("boot_cfg", `NVMPC_OFS_BOOT_CFG, 32'h0000_fb04);
		apb(1'b0, 12'h010, 32'h0, r, e);
		check_bit("pslverr", 1'b1, e);
		check_word("unmapped", 32'h0, r);
		wr(`NVMPC_OFS_UNLOCK, 32'h11);
		cpu(2'h1, 17'h00010, 1'b0);
		dbg(1'b1, 2'h2, 17'h0, 8'h08, 1'b1);
		dbg(1'b1, 2'h2, 17'h1, 8'hf7, 1'b1);
		rdc("status", `NVMPC_OFS_STATUS, 32'h0000_0818);
		check_word("boot_lock", 32'h0000_f708,
			{16'h0000, boot_area_lock_complement, boot_area_lock});
		dbg(1'b1, 2'h2, 17'h2, 8'haa, 1'b1);
		check_bit("readout_lock", 1'b1, readout_lock);
		dbg(1'b0, 2'h0, 17'h0, 8'h00, 1'b0);
		dbg(1'b1, 2'h1, 17'h0, 8'h5a, 1'b0);
		dbg(1'b1, 2'h2, 17'h0, 8'h10, 1'b0);
		check_word("boot_lock", 32'h0000_f708,
			{16'h0000, boot_area_lock_complement, boot_area_lock});
		dbg(1'b1, 2'h2, 17'h2, 8'h00, 1'b0);
		for (int i = 0; i < 2 * EC + 2; i++) begin
			check_bit("erase_prog", i < EC, erase_prog);
			check_bit("erase_data", i >= EC && i < 2 * EC, erase_data);
			check_bit("readout_lock", i < 2 * EC + 1, readout_lock);
			@(posedge pclk);
			#1;
		end
		rst(8'h04, 8'h00, 8'haa);
		rdc("status", `NVMPC_OFS_STATUS, 32'h0000_0012);
		dbg(1'b0, 2'h1, 17'h0, 8'h00, 1'b0);
		wr(`NVMPC_OFS_UNLOCK, 32'h56);
		wr(`NVMPC_OFS_UNLOCK, 32'hae);
		// With the enable low the relock key must not land.
		ce <= 1'b0;
		wr(`NVMPC_OFS_UNLOCK, 32'h11);
		check_bit("in_app", 1'b1, in_app_programming);
		ce <= 1'b1;
		cpu(2'h0, 17'h00000, 1'b1);
		tally_and_finish;
	end
endmodule
